// ---- hdl/asa_serial_adapter.sv ----
// Async serial adapter: bus registers, transmitter, receiver, modem lines.
`timescale 1ns/10ps
`include "asa_consts.svh"
////////////////////////////////////////////////////////////////////////////////
// Operation
// - Div 16/64 receiver self-synchronises to start edge
// - Clear-to-send high hides holding-empty status
// - RTS high only when bits 6:5 are 10
// - Carrier lost holds receiver idle and initialised
// - Carrier lost rise interrupts when enabled
// - Transmit data written on strobe falling edge
// - Transmit write marks holding register full
// - Idle transmitter loads within one bit time
// - Busy transmitter loads next character back-to-back
// - Finished character moves to empty receive holding
// - Data read clears full flag, keeps data
// - Full receive holding blocks further transfers
// - Eight-bit write-only control register
// - Bits 1:0 choose divide by 1/16/64
// - Code 11 is master reset of status
// - Bits 4:2 choose length, parity, stop bits
// - Format changes act immediately
// - Transmit interrupt on 01; 11 sends break
// - Bit 7 enables receiver interrupts
// - Seven-bit modes zero or ignore bit 7
// - Least significant bit travels first
// - Interrupt output follows enabled causes
module asa_serial_adapter
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_cs0,
   input wire logic i_cs1,
   input wire logic i_cs2_n,
   input wire logic i_register_pick,
   input wire logic i_rw,
   input wire logic i_e,
   input wire logic [7:0] i_data,
   output logic [7:0] o_data,
   output logic o_data_oe,
   output logic o_irq_n,
   output logic o_irq_oe,
   input wire logic i_tx_clk,
   input wire logic i_rx_clk,
   input wire logic i_rx_data,
   output logic o_tx_data,
   input wire logic i_cts_n,
   output logic o_rts_n,
   input wire logic i_carrier_lost
);
   import asa_pkg::*;

   function automatic logic fmt_len8(input logic [2:0] f);
      return f[2];
   endfunction

   function automatic logic fmt_par(input logic [2:0] f);
      return !f[2] || f[1];
   endfunction

   function automatic logic fmt_stop2(input logic [2:0] f);
      return !f[1] && (f != `ASA_FMT_8N1);
   endfunction

   function automatic logic [6:0] div_ratio(input logic [1:0] d);
      unique case (d)
         `ASA_DIV_16: return `ASA_RATIO_16;
         `ASA_DIV_64: return `ASA_RATIO_64;
         default: return `ASA_RATIO_1;
      endcase
   endfunction

   logic [7:0] ctl;
   logic [7:0] tx_hold;
   logic [7:0] tx_sh;
   logic [7:0] rx_hold;
   logic [7:0] rx_sh;
   logic [7:0] stat;
   logic [7:0] mask;
   logic [6:0] ratio;
   logic [6:0] tx_cnt;
   logic [6:0] rx_cnt;
   logic [6:0] rx_lim;
   logic [3:0] tx_idx;
   logic [3:0] rx_idx;
   logic [3:0] nbits;
   logic [3:0] last;
   logic [3:0] stop_n;
   asa_tx_e tx_st;
   asa_rx_e rx_st;
   logic tx_holding_empty, rx_holding_full, rx_overrun_flag, fe, pe, dcd_hold, st_armed, rx_par, txo;
   logic e_d, cl_d, txc_d, rxc_d;
   logic sel, e_fall, wr_tdr, wr_ctl, rd_rdr, rd_st, mreset, par, odd;
   logic tx_tick, tx_bit, tx_load, tx_nextbit, rx_tick, rx_hit, rx_done;
   logic pe_calc, irq, rx_cause, tx_cause;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode. The strobe falling edge ends every access.

   assign sel = i_cs0 && i_cs1 && !i_cs2_n;
   assign e_fall = e_d && !i_e && sel;
   assign wr_tdr = e_fall && i_register_pick && !i_rw;
   assign wr_ctl = e_fall && !i_register_pick && !i_rw;
   assign rd_rdr = e_fall && i_register_pick && i_rw;
   assign rd_st = e_fall && !i_register_pick && i_rw;
   assign mreset = ctl[`ASA_CR_DIV] == `ASA_DIV_MR;
   assign ratio = div_ratio(ctl[`ASA_CR_DIV]);
   assign par = fmt_par(ctl[`ASA_CR_FMT]);
   assign odd = ctl[`ASA_CR_ODD];
   assign nbits = fmt_len8(ctl[`ASA_CR_FMT]) ? `ASA_NB8 : `ASA_NB7;
   assign last = (fmt_len8(ctl[`ASA_CR_FMT]) && par) ? `ASA_NB8 : `ASA_NB7;
   assign stop_n = fmt_stop2(ctl[`ASA_CR_FMT]) ? `ASA_STOP2 : `ASA_STOP1;
   assign mask = fmt_len8(ctl[`ASA_CR_FMT]) ? `ASA_MASK8 : `ASA_MASK7;

   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
      begin
         e_d <= 1'b0;
         cl_d <= 1'b0;
         txc_d <= 1'b0;
         rxc_d <= 1'b0;
      end
      else
      begin
         e_d <= i_e;
         cl_d <= i_carrier_lost;
         txc_d <= i_tx_clk;
         rxc_d <= i_rx_clk;
      end

   // Reset leaves the divide bits at the master reset code, as the host expects.
   // reset code held
   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
         ctl <= `ASA_CTL_RESET;
      else if (wr_ctl)
         ctl <= i_data;

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter. Bits change on the falling edge of the transmit clock.

   assign tx_tick = txc_d && !i_tx_clk;
   assign tx_bit = tx_tick && (tx_cnt >= ratio - `ASA_CNT1);
   assign tx_load = tx_bit && !tx_holding_empty && !wr_tdr &&
                    (tx_st == TX_IDLE || (tx_st == TX_STOP && tx_idx >= stop_n));
   assign tx_nextbit = (tx_idx < nbits) ? tx_sh[tx_idx[2:0]] : (^(tx_sh & mask) ^ odd);

   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
         tx_cnt <= `ASA_CNT0;
      else if (mreset)
         tx_cnt <= `ASA_CNT0;
      else if (tx_tick)
         tx_cnt <= tx_bit ? `ASA_CNT0 : tx_cnt + `ASA_CNT1;

   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
         tx_hold <= `ASA_ZERO8;
      else if (wr_tdr)
         tx_hold <= i_data;

   // A write in the load cycle defers the load, so the written character replaces the waiting one.
   // write marks full
   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
         tx_holding_empty <= 1'b1;
      else if (mreset || tx_load)
         tx_holding_empty <= 1'b1;
      else if (wr_tdr)
         tx_holding_empty <= 1'b0;

   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
      begin
         tx_st <= TX_IDLE;
         tx_idx <= `ASA_IDX0;
         tx_sh <= `ASA_ZERO8;
         txo <= `ASA_MARK;
      end
      else if (mreset)
      begin
         tx_st <= TX_IDLE;
         tx_idx <= `ASA_IDX0;
         txo <= `ASA_MARK;
      end
      else if (tx_load)
      begin
         tx_sh <= tx_hold & mask;
         tx_st <= TX_BITS;
         tx_idx <= `ASA_IDX0;
         txo <= `ASA_SPACE;
      end
      else if (tx_bit)
         unique case (tx_st)
            TX_IDLE: txo <= `ASA_MARK;
            TX_BITS:
            begin
               txo <= tx_nextbit;
               tx_idx <= tx_idx + `ASA_IDX1;
               if (tx_idx == last)
               begin
                  tx_st <= TX_STOP;
                  tx_idx <= `ASA_IDX0;
               end
            end
            TX_STOP:
            begin
               txo <= `ASA_MARK;
               if (tx_idx >= stop_n)
                  tx_st <= TX_IDLE;
               else
                  tx_idx <= tx_idx + `ASA_IDX1;
            end
         endcase

   ////////////////////////////////////////////////////////////////////////////
   // Receiver. Samples on the rising edge of the receive clock.

   assign rx_tick = !rxc_d && i_rx_clk;
   assign rx_lim = (rx_st == RX_START) ? (ratio >> 1) - `ASA_CNT1 : ratio - `ASA_CNT1;
   assign rx_hit = rx_tick && (rx_cnt >= rx_lim);
   assign rx_done = rx_hit && rx_st == RX_STOP && !mreset && !i_carrier_lost;
   assign pe_calc = par && ((^rx_sh ^ rx_par) != odd);

   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
      begin
         rx_st <= RX_IDLE;
         rx_cnt <= `ASA_CNT0;
         rx_idx <= `ASA_IDX0;
         rx_sh <= `ASA_ZERO8;
         rx_par <= 1'b0;
      end
      else if (mreset || i_carrier_lost)
      begin
         rx_st <= RX_IDLE;
         rx_cnt <= `ASA_CNT0;
         rx_idx <= `ASA_IDX0;
      end
      else if (rx_tick)
         unique case (rx_st)
            RX_IDLE:
            begin
               rx_cnt <= `ASA_CNT0;
               rx_idx <= `ASA_IDX0;
               if (!i_rx_data)
               begin
                  rx_sh <= `ASA_ZERO8;
                  rx_st <= (ratio == `ASA_RATIO_1) ? RX_BITS : RX_START;
               end
            end
            RX_START:
               if (rx_hit)
               begin
                  rx_cnt <= `ASA_CNT0;
                  rx_st <= i_rx_data ? RX_IDLE : RX_BITS;
               end
               else
                  rx_cnt <= rx_cnt + `ASA_CNT1;
            RX_BITS:
               if (rx_hit)
               begin
                  rx_cnt <= `ASA_CNT0;
                  rx_idx <= rx_idx + `ASA_IDX1;
                  if (rx_idx < nbits)
                     rx_sh[rx_idx[2:0]] <= i_rx_data;
                  else
                     rx_par <= i_rx_data;
                  if (rx_idx == last)
                     rx_st <= RX_STOP;
               end
               else
                  rx_cnt <= rx_cnt + `ASA_CNT1;
            RX_STOP:
               if (rx_hit)
               begin
                  rx_cnt <= `ASA_CNT0;
                  rx_st <= RX_IDLE;
               end
               else
                  rx_cnt <= rx_cnt + `ASA_CNT1;
         endcase

   // A transfer that meets a clearing read in one cycle is dropped and flags an overrun.
   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
      begin
         rx_hold <= `ASA_ZERO8;
         rx_holding_full <= 1'b0;
         rx_overrun_flag <= 1'b0;
         fe <= 1'b0;
         pe <= 1'b0;
      end
      else if (mreset)
      begin
         rx_holding_full <= 1'b0;
         rx_overrun_flag <= 1'b0;
         fe <= 1'b0;
         pe <= 1'b0;
      end
      else
      begin
         if (rd_rdr)
         begin
            rx_holding_full <= 1'b0;
            if (st_armed)
               rx_overrun_flag <= 1'b0;
         end
         if (rx_done)
         begin
            if (!rx_holding_full)
            begin
               rx_hold <= rx_sh & mask;
               rx_holding_full <= 1'b1;
               fe <= !i_rx_data;
               pe <= pe_calc;
            end
            else
               rx_overrun_flag <= 1'b1;
         end
      end

   // Carrier loss and overrun need a status read then a data read to clear.
   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
      begin
         st_armed <= 1'b0;
         dcd_hold <= 1'b0;
      end
      else if (mreset)
      begin
         st_armed <= 1'b0;
         dcd_hold <= 1'b0;
      end
      else
      begin
         if (rd_st)
            st_armed <= 1'b1;
         else if (rd_rdr)
            st_armed <= 1'b0;
         if (rd_rdr && st_armed)
            dcd_hold <= 1'b0;
         if (i_carrier_lost && !cl_d)
            dcd_hold <= 1'b1;
      end

   ////////////////////////////////////////////////////////////////////////////
   // Status, interrupt and pin outputs.

   assign rx_cause = ctl[`ASA_CR_RXIE] && (stat[`ASA_ST_RX_HOLDING_FULL] || rx_overrun_flag || dcd_hold);
   assign tx_cause = (ctl[`ASA_CR_TXC] == `ASA_TX_IE) && stat[`ASA_ST_TX_HOLDING_EMPTY];
   assign irq = rx_cause || tx_cause;

   always_comb
   begin
      stat = `ASA_ZERO8;
      stat[`ASA_ST_RX_HOLDING_FULL] = rx_holding_full && !i_carrier_lost;
      stat[`ASA_ST_TX_HOLDING_EMPTY] = tx_holding_empty && !i_cts_n && !mreset;
      stat[`ASA_ST_DCD] = dcd_hold || i_carrier_lost;
      stat[`ASA_ST_CTS] = i_cts_n;
      stat[`ASA_ST_FE] = fe;
      stat[`ASA_ST_RX_OVERRUN_FLAG] = rx_overrun_flag;
      stat[`ASA_ST_PE] = pe;
      stat[`ASA_ST_IRQ] = irq;
   end

   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
      begin
         o_data <= `ASA_ZERO8;
         o_data_oe <= 1'b0;
      end
      else if (sel && i_e && i_rw)
      begin
         o_data <= i_register_pick ? rx_hold : stat;
         o_data_oe <= 1'b1;
      end
      else
         o_data_oe <= 1'b0;

   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
      begin
         o_irq_n <= 1'b1;
         o_irq_oe <= 1'b0;
         o_tx_data <= `ASA_MARK;
         o_rts_n <= 1'b0;
      end
      else
      begin
         o_irq_n <= !irq;
         o_irq_oe <= irq;
         o_tx_data <= (ctl[`ASA_CR_TXC] == `ASA_TX_BREAK) ? `ASA_SPACE : txo;
         o_rts_n <= ctl[`ASA_CR_TXC] == `ASA_TX_RTS_OFF;
      end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_rts_level:
   assert property (ctl[`ASA_CR_TXC] != `ASA_TX_RTS_OFF |=> !o_rts_n)
      else $error("rts high with wrong control code");
   a_cts_inhibit:
   assert property (i_cts_n && !ctl[`ASA_CR_RXIE] |=> !o_irq_oe && o_irq_n)
      else $error("holding empty shown while cts high");
   a_write_full:
   assert property (wr_tdr && !mreset |=> !tx_holding_empty)
      else $error("write did not mark holding full");
   a_load_empty:
   assert property (tx_load && !mreset |=> tx_holding_empty && tx_st == TX_BITS
                    ##1 o_tx_data == `ASA_SPACE)
      else $error("load did not start frame");
   a_read_clear:
   assert property (rd_rdr && !rx_done && !mreset |=> !rx_holding_full && $stable(rx_hold))
      else $error("data read did not clear full");
   a_full_block:
   assert property (rx_holding_full && !rd_rdr && !mreset |=> rx_holding_full && $stable(rx_hold))
      else $error("full holding register changed");
   a_carrier_init:
   assert property (i_carrier_lost |=> rx_st == RX_IDLE && !rx_done)
      else $error("receiver active with carrier lost");
   a_break_out:
   assert property (ctl[`ASA_CR_TXC] == `ASA_TX_BREAK |=> o_tx_data == `ASA_SPACE)
      else $error("break level not sent");
   a_irq_follow:
   assert property (irq |=> o_irq_oe && !o_irq_n)
      else $error("interrupt output not active");
   a_mreset_clear:
   assert property (mreset |=> !rx_holding_full && !rx_overrun_flag && !fe && !pe && !dcd_hold)
      else $error("master reset left status set");
   a_carrier_irq:
   assert property (ctl[`ASA_CR_RXIE] && i_carrier_lost && !cl_d && !wr_ctl && !mreset
                    |=> ##1 o_irq_oe)
      else $error("carrier loss raised no interrupt");

   c_rx_char: cover property (rx_done && !rx_holding_full);
   c_overrun: cover property (rx_done && rx_holding_full);
   c_tx_b2b: cover property (tx_load && tx_st == TX_STOP);
endmodule

// ---- hdl/asa_consts.svh ----
// Field positions, codes and reset values of the async serial adapter.
`ifndef ASA_CONSTS_SVH
`define ASA_CONSTS_SVH
`define ASA_DIV_1 2'b00
`define ASA_DIV_16 2'b01
`define ASA_DIV_64 2'b10
`define ASA_DIV_MR 2'b11
`define ASA_RATIO_1 7'h01
`define ASA_RATIO_16 7'h10
`define ASA_RATIO_64 7'h40
`define ASA_CNT1 7'h01
`define ASA_CNT0 7'h00
`define ASA_CTL_RESET 8'h03
`define ASA_CR_DIV 1:0
`define ASA_CR_FMT 4:2
`define ASA_CR_TXC 6:5
`define ASA_CR_RXIE 7
`define ASA_CR_ODD 2
`define ASA_TX_IE 2'b01
`define ASA_TX_RTS_OFF 2'b10
`define ASA_TX_BREAK 2'b11
`define ASA_FMT_8N1 3'b101
`define ASA_ST_RX_HOLDING_FULL 0
`define ASA_ST_TX_HOLDING_EMPTY 1
`define ASA_ST_DCD 2
`define ASA_ST_CTS 3
`define ASA_ST_FE 4
`define ASA_ST_RX_OVERRUN_FLAG 5
`define ASA_ST_PE 6
`define ASA_ST_IRQ 7
`define ASA_NB7 4'h7
`define ASA_NB8 4'h8
`define ASA_IDX0 4'h0
`define ASA_IDX1 4'h1
`define ASA_STOP1 4'h1
`define ASA_STOP2 4'h2
`define ASA_MASK7 8'h7f
`define ASA_MASK8 8'hff
`define ASA_ZERO8 8'h00
`define ASA_MARK 1'b1
`define ASA_SPACE 1'b0
`endif

// ---- hdl/asa_pkg.sv ----
// State types of the async serial adapter.
package asa_pkg;
   typedef enum logic [1:0] {TX_IDLE, TX_BITS, TX_STOP} asa_tx_e;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} asa_rx_e;
endpackage

// ---- verification/asa_modem_model.sv ----
// Serial peripheral model: bit-rate clocks, frame sender and frame catcher.
`timescale 1ns/10ps
module asa_modem_model
(
   input wire logic i_tx_data,
   output logic o_tx_clk,
   output logic o_rx_clk,
   output logic o_rx_data
);
   localparam int TICK_NS = 80;
   initial
   begin
      o_tx_clk = 1'b1;
      o_rx_clk = 1'b1;
      o_rx_data = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // The receive clock runs at its own rate so that no phase relation is assumed.
   // Both clocks toggle only on falling system clock edges, away from sampling.
   always #(TICK_NS / 2) o_tx_clk = ~o_tx_clk;
   always #30 o_rx_clk = ~o_rx_clk;
   ////////////////////////////////////////////////////////////////////////////////
   // Bits change on falling receive clock edges, away from the sampling edge.
   task automatic send_frame(input logic [11:0] bits, input int nbits, input int ratio);
      for (int i = 0; i < nbits; i++)
      begin
         repeat (ratio) @(negedge o_rx_clk);
         o_rx_data = bits[i];
      end
      repeat (ratio) @(negedge o_rx_clk);
      o_rx_data = 1'b1;
   endtask
   // A low pulse shorter than half a bit, which a receiver must not take as a start.
   task automatic glitch(input int ticks);
      @(negedge o_rx_clk);
      o_rx_data = 1'b0;
      repeat (ticks) @(negedge o_rx_clk);
      o_rx_data = 1'b1;
   endtask
   // Returns in the middle of the last bit, so a following start edge is not missed.
   task automatic catch_frame(input int nbits, input int ratio, output logic [11:0] bits);
      int t;
      bits = 12'hfff;
      for (t = 0; t < 20000 && i_tx_data !== 1'b0; t++)
         #10;
      if (t < 20000)
      begin
         #(ratio * TICK_NS / 2);
         bits[0] = i_tx_data;
         for (int i = 1; i < nbits; i++)
         begin
            #(ratio * TICK_NS);
            bits[i] = i_tx_data;
         end
      end
   endtask
endmodule

// ---- verification/asa_serial_adapter_tb_top.sv ----
// Testbench for the async serial adapter: bus tasks, scenarios and verdict.
`timescale 1ns/10ps
module asa_serial_adapter_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cs = 1'b0;
   logic rs = 1'b0;
   logic rw = 1'b1;
   logic e = 1'b0;
   logic cts_n = 1'b0;
   logic car = 1'b0;
   logic [7:0] din = 8'h00;
   logic [7:0] dout;
   logic [7:0] q;
   logic [7:0] st;
   logic tx, txc, rxc, rxd, irq_n, irq_oe, rts_n, oe;
   int miscompares = 0;
   int n_compared = 0;

   asa_serial_adapter uut
   (
      .i_clk(clk), .i_rst(rst), .i_cs0(cs), .i_cs1(cs), .i_cs2_n(~cs),
      .i_register_pick(rs), .i_rw(rw), .i_e(e), .i_data(din), .o_data(dout),
      .o_data_oe(oe), .o_irq_n(irq_n), .o_irq_oe(irq_oe), .i_tx_clk(txc),
      .i_rx_clk(rxc), .i_rx_data(rxd), .o_tx_data(tx), .i_cts_n(cts_n),
      .o_rts_n(rts_n), .i_carrier_lost(car)
   );
   asa_modem_model modem
   (
      .i_tx_data(tx), .o_tx_clk(txc), .o_rx_clk(rxc), .o_rx_data(rxd)
   );

   always #5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("FAIL %0t %s: got %h, expected %h", $time, what, got, exp);
      end
   endtask
   // One bus access; reads hold the strobe two clocks so the registered data is settled.
   task automatic acc(input logic r, input logic rd, input logic sel, input logic [7:0] d);
      @(negedge clk);
      cs = sel;
      rs = r;
      rw = rd;
      din = d;
      e = 1'b1;
      repeat (rd ? 2 : 1) @(negedge clk);
      q = dout;
      e = 1'b0;
      @(negedge clk);
      cs = 1'b0;
   endtask
   task automatic wr(input logic r, input logic [7:0] d);
      acc(r, 1'b0, 1'b1, d);
   endtask
   task automatic rd_st();
      acc(1'b0, 1'b1, 1'b1, 8'h00);
      st = q;
   endtask
   task automatic wait_st(input logic [7:0] m);
      int n;
      q = 8'h00;
      for (n = 0; n < 3000 && (q & m) !== m; n++)
         acc(1'b0, 1'b1, 1'b1, 8'h00);
      st = q;
      if ((q & m) !== m)
      begin
         miscompares++;
         $display("FAIL %0t status wait timed out", $time);
         close_out();
      end
   endtask
   function automatic logic [11:0] mk_frame(input logic [7:0] d, input logic [2:0] f,
      output int n);
      logic [11:0] b;
      b = 12'hffe;
      for (int i = 0; i < 8; i++)
         if (i < 7 || f[2])
            b[i + 1] = d[i];
      n = f[2] ? 9 : 8;
      if (f[2:1] != 2'b10)
      begin
         b[n] = (f[2] ? ^d : ^d[6:0]) ^ f[0];
         n++;
      end
      n += (f == 3'b000 || f == 3'b001 || f == 3'b100) ? 2 : 1;
      return b;
   endfunction
   task automatic rx_char(input logic [7:0] d, input logic [2:0] f, input logic bad_par);
      logic [11:0] b;
      int n;
      b = mk_frame(d, f, n);
      b[n - 2] = b[n - 2] ^ bad_par;
      modem.send_frame(b, n, 16);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk({8'h0, tx, rts_n, irq_oe, oe}, 12'h008, "pins after reset");
      wr(1'b0, 8'h03);
      wr(1'b0, 8'h15);
      rd_st();
      chk({4'h0, st & 8'h81}, 12'h000, "status after init");
   endtask
   task automatic t_ctl();
      for (int c = 0; c < 4; c++)
      begin
         wr(1'b0, {1'b0, 2'(c), 5'b10101});
         repeat (2) @(negedge clk);
         chk({11'h0, rts_n}, {11'h0, c == 2}, "request-to-send level");
         chk({11'h0, irq_n}, {11'h0, c != 1}, "transmit interrupt");
         if (c == 3)
            chk({11'h0, tx}, 12'h000, "break level");
         if (c == 1)
         begin
            cts_n = 1'b1;
            rd_st();
            chk({4'h0, st & 8'h0a}, 12'h008, "clear-to-send hides empty");
            chk({11'h0, irq_n}, 12'h001, "interrupt gone with empty");
            cts_n = 1'b0;
         end
      end
      wr(1'b0, 8'h15);
      acc(1'b0, 1'b0, 1'b0, 8'h55);
      repeat (2) @(negedge clk);
      chk({11'h0, rts_n}, 12'h000, "unselected write ignored");
   endtask
   task automatic t_tx(input logic [7:0] c, input logic [7:0] d, input int ratio);
      logic [11:0] exp;
      logic [11:0] got;
      int n;
      exp = mk_frame(d, c[4:2], n);
      wr(1'b0, c);
      fork
         modem.catch_frame(n, ratio, got);
         wr(1'b1, d);
      join
      chk(got, exp, "transmitted frame");
      repeat (ratio * 16) @(negedge clk);
   endtask
   task automatic t_b2b();
      logic [11:0] ga;
      logic [11:0] gb;
      int n;
      wr(1'b0, 8'h15);
      fork
         begin
            modem.catch_frame(10, 16, ga);
            modem.catch_frame(10, 16, gb);
         end
         begin
            wr(1'b1, 8'h5a);
            wait_st(8'h02);
            wr(1'b1, 8'hc3);
            rd_st();
            chk({4'h0, st & 8'h02}, 12'h000, "write marks holding full");
         end
      join
      chk(ga, mk_frame(8'h5a, 3'b101, n), "first frame");
      chk(gb, mk_frame(8'hc3, 3'b101, n), "second frame follows");
      repeat (300) @(negedge clk);
   endtask
   task automatic t_rx();
      logic [11:0] b;
      int n;
      wr(1'b0, 8'h95);
      modem.glitch(4);
      repeat (1500) @(negedge clk);
      rd_st();
      chk({4'h0, st & 8'h01}, 12'h000, "short start pulse ignored");
      rx_char(8'h3c, 3'b101, 1'b0);
      wait_st(8'h01);
      chk({4'h0, st & 8'h81}, 12'h081, "full raises request");
      chk({11'h0, irq_n}, 12'h000, "interrupt pin while full");
      acc(1'b1, 1'b1, 1'b1, 8'h00);
      chk({4'h0, q}, 12'h03c, "received byte");
      rd_st();
      chk({4'h0, st & 8'h01}, 12'h000, "read clears full");
      chk({11'h0, irq_n}, 12'h001, "interrupt released");
      acc(1'b1, 1'b1, 1'b1, 8'h00);
      chk({4'h0, q}, 12'h03c, "byte kept after read");
      rx_char(8'h11, 3'b101, 1'b0);
      rx_char(8'h22, 3'b101, 1'b0);
      rd_st();
      chk({4'h0, st & 8'h21}, 12'h021, "second byte overruns");
      acc(1'b1, 1'b1, 1'b1, 8'h00);
      chk({4'h0, q}, 12'h011, "first byte survives");
      rd_st();
      chk({4'h0, st & 8'h21}, 12'h000, "overrun cleared");
      wr(1'b0, 8'h94);
      b = mk_frame(8'h5c, 3'b101, n);
      modem.send_frame(b, n, 1);
      wait_st(8'h01);
      acc(1'b1, 1'b1, 1'b1, 8'h00);
      chk({4'h0, q}, 12'h05c, "byte at divide by one");
   endtask
   task automatic t_par();
      wr(1'b0, 8'h89);
      rx_char(8'hea, 3'b010, 1'b0);
      wait_st(8'h01);
      chk({4'h0, st & 8'h40}, 12'h000, "good parity");
      acc(1'b1, 1'b1, 1'b1, 8'h00);
      chk({4'h0, q}, 12'h06a, "seven-bit byte");
      rx_char(8'h35, 3'b010, 1'b1);
      wait_st(8'h01);
      chk({4'h0, st & 8'h40}, 12'h040, "bad parity flagged");
      acc(1'b1, 1'b1, 1'b1, 8'h00);
   endtask
   task automatic t_car();
      wr(1'b0, 8'h15);
      car = 1'b1;
      repeat (4) @(negedge clk);
      chk({11'h0, irq_n}, 12'h001, "masked carrier loss");
      rx_char(8'h77, 3'b101, 1'b0);
      rd_st();
      chk({4'h0, st & 8'h05}, 12'h004, "receiver held off");
      acc(1'b1, 1'b1, 1'b1, 8'h00);
      car = 1'b0;
      wr(1'b0, 8'h95);
      car = 1'b1;
      repeat (4) @(negedge clk);
      chk({11'h0, irq_n}, 12'h000, "carrier loss interrupts");
      rd_st();
      chk({4'h0, st & 8'h84}, 12'h084, "carrier loss in status");
      car = 1'b0;
      acc(1'b1, 1'b1, 1'b1, 8'h00);
      repeat (2) @(negedge clk);
      chk({11'h0, irq_n}, 12'h001, "carrier interrupt cleared");
   endtask
   task automatic t_mr();
      rx_char(8'h42, 3'b101, 1'b0);
      wait_st(8'h01);
      wr(1'b0, 8'h57);
      repeat (2) @(negedge clk);
      chk({11'h0, rts_n}, 12'h001, "other control bits kept");
      rd_st();
      chk({4'h0, st & 8'h01}, 12'h000, "master reset clears full");
      wr(1'b0, 8'h15);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_ctl();
      for (int f = 0; f < 8; f++)
         t_tx({3'b000, 3'(f), 2'b00}, 8'hb4 ^ 8'(f), 1);
      t_tx(8'h15, 8'ha5, 16);
      t_tx(8'h16, 8'h81, 64);
      t_b2b();
      t_rx();
      t_par();
      t_car();
      t_mr();
      close_out();
   end
endmodule
